// File: design/exc_pkg.sv
// exception unit package: layout of the status area, fcw fields, kinds and states.
// assumes the nonsegmented variant: 16-bit addresses and two-word status blocks.
package exc_pkg;
    localparam int          WORD_W        = 16;
    localparam int          PIN_W         = 4;
    // pin order inside the synchroniser vector
    localparam int          PIN_VEC       = 0;
    localparam int          PIN_NVEC      = 1;
    localparam int          PIN_NMI       = 2;
    localparam int          PIN_SEG       = 3;
    // flag_control_word enable bits
    localparam int          FCW_VEC_EN    = 12;
    localparam int          FCW_NVEC_EN   = 11;
    // byte offsets of the status blocks inside the area
    localparam logic [15:0] OFS_EXT_TRAP  = 16'h0004;
    localparam logic [15:0] OFS_PRIV_TRAP = 16'h0008;
    localparam logic [15:0] OFS_SYSCALL   = 16'h000C;
    localparam logic [15:0] OFS_SEG_TRAP  = 16'h0010;
    localparam logic [15:0] OFS_NMI       = 16'h0014;
    localparam logic [15:0] OFS_NVEC      = 16'h0018;
    localparam logic [15:0] OFS_VEC_FCW   = 16'h001C;
    localparam logic [15:0] OFS_VEC_TABLE = 16'h001E;
    localparam logic [15:0] OFS_BLOCK_PC  = 16'h0002;
    localparam logic [7:0]  BASE_LOW_BYTE = 8'h00;
    localparam logic [7:0]  BASE_RESET    = 8'h00;
    localparam logic [15:0] WORD_ZERO     = 16'h0000;
    localparam logic [PIN_W-1:0] PINS_IDLE = 4'hF;

    typedef enum logic [2:0] {
        K_EXT, K_PRIV, K_SYSCALL, K_SEG, K_NMI, K_VEC, K_NVEC
    } kind_t;

    typedef enum logic [1:0] {
        M_NONE, M_PUSH, M_POP, M_AREA_READ
    } mem_op_t;

    typedef enum {
        S_IDLE, S_CHECK, S_ACK, S_PUSH_PC, S_PUSH_FCW, S_PUSH_ID,
        S_LOAD_FCW, S_LOAD_PC, S_DONE, S_POP_ID, S_POP_FCW, S_POP_PC
    } state_t;

    // request to the memory side
    typedef struct packed {
        logic        req;
        mem_op_t     op;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_t;

    // status handed back to the core
    typedef struct packed {
        logic        load;
        logic [15:0] pc;
        logic [15:0] flag_control_word;
    } status_t;
endpackage

// File: design/pin_sync.sv
// two-stage synchroniser for a group of asynchronous pins.
// assumes pins are quasi-static between edges; no glitch filter.
`timescale 1ns/1ps
module pin_sync #(
    parameter int                W    = 4,
    parameter logic [W-1:0]      IDLE = '1
) (
    input  wire logic           i_clock,
    input  wire logic           i_rst,
    input  wire logic [W-1:0]   i_pins,
    output logic      [W-1:0]   o_pins
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_t;

    sync_t st_reg;
    sync_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.meta = i_pins;
        st_next.sync = st_reg.meta;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= '{meta: IDLE, sync: IDLE};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_pins = st_reg.sync;
endmodule

// File: design/exception_vectoring_priority.sv
// exception entry and return sequencer beside the instruction core.
// assumes the core offers instruction boundaries, pc values and a stack-side memory port;
// request pins are asynchronous and active low, nmi acts on its falling edge.
`timescale 1ns/1ps
// Contract
// - syscall and interrupts save next pc, or current pc if block move unfinished.
// - after saving, fetch new control word and pc from status area.
// - each status block two words here; one block per non-vectored kind.
// - vectored: shared control word, pc from table at identifier low byte times two.
// - base pointer holds high offset byte; low byte always zero.
// - base pointer reached only by load control instruction, one word wide.
// - execution starts at loaded pc; loaded control word governs interrupt enables.
// - priority: reset, internal trap, nmi, segment trap, vectored, nonvectored.
// - reset acts immediately ahead of anything else.
// - take highest enabled exception; traps and nmi always enabled.
// - repeat while enabled exceptions remain, saving previous handler status.
// - return pops and drops identifier, then restores control word and pc.
// - segmented return outside segmented mode is undefined; unconstrained.
// - internal traps never coincide, so no arbitration between them.
// - entry pushes return pc, then old control word, then identifier.
// - identifier: trapped instruction first word, or acknowledge data for external.
// - system mode before acknowledge, old control word untouched, until handler.
module exception_vectoring_priority (
    input  wire logic               i_clock,
    input  wire logic               i_rst,
    // core side
    input  wire logic               i_boundary,
    input  wire logic [15:0]        i_next_pc,
    input  wire logic [15:0]        i_cur_pc,
    input  wire logic               i_block_incomplete,
    input  wire logic [15:0]        i_fcw,
    input  wire logic               i_trap_req,
    input  wire exc_pkg::kind_t     i_trap_kind,
    input  wire logic [15:0]        i_trap_pc,
    input  wire logic [15:0]        i_trap_word,
    input  wire logic               i_return_req,
    input  wire logic               i_ctl_write,
    input  wire logic [15:0]        i_ctl_wdata,
    output logic [15:0]             o_ctl_rdata,
    output exc_pkg::status_t        o_status,
    output logic                    o_busy,
    output logic                    o_system_mode,
    // request pins, active low
    input  wire logic               i_vectored_request_n,
    input  wire logic               i_nonvectored_request_n,
    input  wire logic               i_nmi_n,
    input  wire logic               i_segment_fault_input_n,
    // acknowledge cycle
    output logic                    o_ack_req,
    output exc_pkg::kind_t          o_ack_kind,
    input  wire logic               i_ack_done,
    input  wire logic [15:0]        i_ack_id,
    // memory side: pushes and pops on the system stack, reads of the area
    output exc_pkg::mem_req_t       o_mem,
    input  wire logic               i_mem_ready,
    input  wire logic [15:0]        i_mem_rdata
);
    typedef struct packed {
        exc_pkg::state_t   state;
        exc_pkg::kind_t    kind;
        logic [15:0]       ret_pc;
        logic [15:0]       old_fcw;
        logic [15:0]       id;
        logic [15:0]       new_fcw;
        logic [15:0]       new_pc;
        logic [7:0]        base_hi;
        logic              trap_pend;
        exc_pkg::kind_t    trap_kind;
        logic [15:0]       trap_pc;
        logic [15:0]       trap_word;
        logic              nmi_pend;
        logic              nmi_prev_n;
        logic              load;
    } st_t;

    st_t                       st_reg;
    st_t                       st_next;
    logic [exc_pkg::PIN_W-1:0] pins_sync;
    logic                      vec_req;
    logic                      nvec_req;
    logic                      seg_req;
    logic                      nmi_fall;
    logic                      any_pend;
    exc_pkg::kind_t            pick;
    logic [15:0]               base;
    logic [15:0]               blk_ofs;

    pin_sync #(
        .W    (exc_pkg::PIN_W),
        .IDLE (exc_pkg::PINS_IDLE)
    ) u_pin_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_pins  ({i_segment_fault_input_n, i_nmi_n,
                   i_nonvectored_request_n, i_vectored_request_n}),
        .o_pins  (pins_sync)
    );

    assign vec_req  = ~pins_sync[exc_pkg::PIN_VEC];
    assign nvec_req = ~pins_sync[exc_pkg::PIN_NVEC];
    assign seg_req  = ~pins_sync[exc_pkg::PIN_SEG];
    // edge seen on the synchronised level, never on the first stage
    assign nmi_fall = st_reg.nmi_prev_n & ~pins_sync[exc_pkg::PIN_NMI];
    assign base     = {st_reg.base_hi, exc_pkg::BASE_LOW_BYTE};

    // priority pick, enables from the fcw now in force
    always_comb begin
        any_pend = 1'b1;
        pick     = exc_pkg::K_NVEC;
        if (st_reg.trap_pend) begin
            pick = st_reg.trap_kind;
        end else if (st_reg.nmi_pend) begin
            pick = exc_pkg::K_NMI;
        end else if (seg_req) begin
            pick = exc_pkg::K_SEG;
        end else if (vec_req && st_reg.old_fcw[exc_pkg::FCW_VEC_EN]) begin
            pick = exc_pkg::K_VEC;
        end else if (nvec_req && st_reg.old_fcw[exc_pkg::FCW_NVEC_EN]) begin
            pick = exc_pkg::K_NVEC;
        end else begin
            any_pend = 1'b0;
        end
    end

    // block offset by kind
    always_comb begin
        case (st_reg.kind)
            exc_pkg::K_EXT:     blk_ofs = exc_pkg::OFS_EXT_TRAP;
            exc_pkg::K_PRIV:    blk_ofs = exc_pkg::OFS_PRIV_TRAP;
            exc_pkg::K_SYSCALL: blk_ofs = exc_pkg::OFS_SYSCALL;
            exc_pkg::K_SEG:     blk_ofs = exc_pkg::OFS_SEG_TRAP;
            exc_pkg::K_NMI:     blk_ofs = exc_pkg::OFS_NMI;
            exc_pkg::K_VEC:     blk_ofs = exc_pkg::OFS_VEC_FCW;
            exc_pkg::K_NVEC:    blk_ofs = exc_pkg::OFS_NVEC;
            default:            blk_ofs = exc_pkg::OFS_NVEC;
        endcase
    end

    always_comb begin
        st_next            = st_reg;
        st_next.load       = 1'b0;
        st_next.nmi_prev_n = pins_sync[exc_pkg::PIN_NMI];
        o_mem              = '{req: 1'b0, op: exc_pkg::M_NONE,
                               addr: exc_pkg::WORD_ZERO, wdata: exc_pkg::WORD_ZERO};
        o_ack_req          = 1'b0;

        if (i_ctl_write) begin
            st_next.base_hi = i_ctl_wdata[15:8];
        end

        case (st_reg.state)
            exc_pkg::S_IDLE: begin
                if (i_boundary) begin
                    st_next.old_fcw = i_fcw;
                    // unfinished block move resumes at itself
                    st_next.ret_pc  = i_block_incomplete ? i_cur_pc : i_next_pc;
                    st_next.state   = exc_pkg::S_CHECK;
                end else if (i_return_req) begin
                    // nonsegmented only, so return is always defined here
                    st_next.state = exc_pkg::S_POP_ID;
                end
            end
            exc_pkg::S_CHECK: begin
                if (any_pend) begin
                    st_next.kind = pick;
                    if (pick == exc_pkg::K_EXT || pick == exc_pkg::K_PRIV ||
                        pick == exc_pkg::K_SYSCALL) begin
                        st_next.id        = st_reg.trap_word;
                        st_next.trap_pend = 1'b0;
                        if (pick != exc_pkg::K_SYSCALL) begin
                            st_next.ret_pc = st_reg.trap_pc;
                        end
                        st_next.state = exc_pkg::S_PUSH_PC;
                    end else begin
                        st_next.state = exc_pkg::S_ACK;
                    end
                end else if (st_reg.load) begin
                    st_next.state = exc_pkg::S_IDLE;
                end else begin
                    // no exception at this boundary
                    st_next.state = exc_pkg::S_IDLE;
                end
            end
            exc_pkg::S_ACK: begin
                o_ack_req = 1'b1;
                if (i_ack_done) begin
                    st_next.id    = i_ack_id;
                    st_next.state = exc_pkg::S_PUSH_PC;
                    if (st_reg.kind == exc_pkg::K_NMI) begin
                        st_next.nmi_pend = 1'b0;
                    end
                end
            end
            exc_pkg::S_PUSH_PC: begin
                o_mem = '{req: 1'b1, op: exc_pkg::M_PUSH,
                          addr: exc_pkg::WORD_ZERO, wdata: st_reg.ret_pc};
                if (i_mem_ready) begin
                    st_next.state = exc_pkg::S_PUSH_FCW;
                end
            end
            exc_pkg::S_PUSH_FCW: begin
                o_mem = '{req: 1'b1, op: exc_pkg::M_PUSH,
                          addr: exc_pkg::WORD_ZERO, wdata: st_reg.old_fcw};
                if (i_mem_ready) begin
                    st_next.state = exc_pkg::S_PUSH_ID;
                end
            end
            exc_pkg::S_PUSH_ID: begin
                o_mem = '{req: 1'b1, op: exc_pkg::M_PUSH,
                          addr: exc_pkg::WORD_ZERO, wdata: st_reg.id};
                if (i_mem_ready) begin
                    st_next.state = exc_pkg::S_LOAD_FCW;
                end
            end
            exc_pkg::S_LOAD_FCW: begin
                o_mem = '{req: 1'b1, op: exc_pkg::M_AREA_READ,
                          addr: base + blk_ofs, wdata: exc_pkg::WORD_ZERO};
                if (i_mem_ready) begin
                    st_next.new_fcw = i_mem_rdata;
                    st_next.state   = exc_pkg::S_LOAD_PC;
                end
            end
            exc_pkg::S_LOAD_PC: begin
                o_mem.req = 1'b1;
                o_mem.op  = exc_pkg::M_AREA_READ;
                if (st_reg.kind == exc_pkg::K_VEC) begin
                    // odd ids land between entries on the segmented part only
                    o_mem.addr = base + exc_pkg::OFS_VEC_TABLE
                               + {7'h00, st_reg.id[7:0], 1'b0};
                end else begin
                    o_mem.addr = base + blk_ofs + exc_pkg::OFS_BLOCK_PC;
                end
                if (i_mem_ready) begin
                    st_next.new_pc = i_mem_rdata;
                    st_next.state  = exc_pkg::S_DONE;
                end
            end
            exc_pkg::S_DONE: begin
                // loaded status becomes the old status of any further exception
                st_next.old_fcw = st_reg.new_fcw;
                st_next.ret_pc  = st_reg.new_pc;
                st_next.load    = 1'b1;
                st_next.state   = exc_pkg::S_CHECK;
            end
            exc_pkg::S_POP_ID: begin
                o_mem = '{req: 1'b1, op: exc_pkg::M_POP,
                          addr: exc_pkg::WORD_ZERO, wdata: exc_pkg::WORD_ZERO};
                if (i_mem_ready) begin
                    st_next.state = exc_pkg::S_POP_FCW;
                end
            end
            exc_pkg::S_POP_FCW: begin
                o_mem = '{req: 1'b1, op: exc_pkg::M_POP,
                          addr: exc_pkg::WORD_ZERO, wdata: exc_pkg::WORD_ZERO};
                if (i_mem_ready) begin
                    st_next.new_fcw = i_mem_rdata;
                    st_next.state   = exc_pkg::S_POP_PC;
                end
            end
            exc_pkg::S_POP_PC: begin
                o_mem = '{req: 1'b1, op: exc_pkg::M_POP,
                          addr: exc_pkg::WORD_ZERO, wdata: exc_pkg::WORD_ZERO};
                if (i_mem_ready) begin
                    st_next.new_pc = i_mem_rdata;
                    st_next.load   = 1'b1;
                    st_next.state  = exc_pkg::S_IDLE;
                end
            end
            default: begin
                st_next.state = exc_pkg::S_IDLE;
            end
        endcase

        // arrivals win over the clears above
        if (i_trap_req) begin
            st_next.trap_pend = 1'b1;
            st_next.trap_kind = i_trap_kind;
            st_next.trap_pc   = i_trap_pc;
            st_next.trap_word = i_trap_word;
        end
        if (nmi_fall) begin
            st_next.nmi_pend = 1'b1;
        end
    end

    // async reset overrides every sequence in flight
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= '{state: exc_pkg::S_IDLE, kind: exc_pkg::K_NVEC,
                        ret_pc: exc_pkg::WORD_ZERO, old_fcw: exc_pkg::WORD_ZERO,
                        id: exc_pkg::WORD_ZERO, new_fcw: exc_pkg::WORD_ZERO,
                        new_pc: exc_pkg::WORD_ZERO, base_hi: exc_pkg::BASE_RESET,
                        trap_pend: 1'b0, trap_kind: exc_pkg::K_EXT,
                        trap_pc: exc_pkg::WORD_ZERO, trap_word: exc_pkg::WORD_ZERO,
                        nmi_pend: 1'b0, nmi_prev_n: 1'b1, load: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_ctl_rdata   = base;
    assign o_status      = '{load: st_reg.load, pc: st_reg.new_pc,
                             flag_control_word: st_reg.new_fcw};
    assign o_busy        = st_reg.state != exc_pkg::S_IDLE;
    assign o_ack_kind    = st_reg.kind;
    // system mode from acknowledge until the handler starts
    assign o_system_mode = st_reg.state inside {exc_pkg::S_ACK, exc_pkg::S_PUSH_PC,
                           exc_pkg::S_PUSH_FCW, exc_pkg::S_PUSH_ID,
                           exc_pkg::S_LOAD_FCW, exc_pkg::S_LOAD_PC,
                           exc_pkg::S_DONE};
endmodule

// File: verif/exc_peer.sv
// partner model: system stack, status area and acknowledge responder.
// assumes one request at a time; area words read back as the inverted address.
`timescale 1ns/1ps
module exc_peer (
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    input  wire exc_pkg::mem_req_t i_mem,
    input  wire logic              i_slow,
    input  wire logic              i_ack_req,
    input  wire logic [15:0]       i_id,
    output logic                   o_mem_ready,
    output logic [15:0]            o_mem_rdata,
    output logic                   o_ack_done,
    output logic [15:0]            o_ack_id
);
    logic [15:0] stack_q [0:15];
    logic [3:0]  sp_q;
    logic [1:0]  wait_q;
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sp_q        <= 4'h0;
            wait_q      <= 2'h0;
            o_mem_ready <= 1'b0;
            o_ack_done  <= 1'b0;
            o_mem_rdata <= 16'h0000;
            o_ack_id    <= 16'h0000;
        end else begin
            o_mem_ready <= 1'b0;
            o_ack_done  <= 1'b0;
            // released bus toggles so stale data never looks valid
            o_mem_rdata <= ~o_mem_rdata;
            o_ack_id    <= ~o_ack_id;
            if ((i_mem.req || i_ack_req) && !o_mem_ready && !o_ack_done) begin
                if (wait_q != {i_slow, i_slow}) begin
                    wait_q <= wait_q + 2'h1;
                end else begin
                    wait_q <= 2'h0;
                    if (i_ack_req) begin
                        // one responder settles the identifier
                        o_ack_done <= 1'b1;
                        o_ack_id   <= i_id;
                    end else begin
                        o_mem_ready <= 1'b1;
                        case (i_mem.op)
                            exc_pkg::M_PUSH: begin
                                stack_q[sp_q] <= i_mem.wdata;
                                sp_q          <= sp_q + 4'h1;
                            end
                            exc_pkg::M_POP: begin
                                o_mem_rdata <= stack_q[sp_q - 4'h1];
                                sp_q        <= sp_q - 4'h1;
                            end
                            default: o_mem_rdata <= ~i_mem.addr;
                        endcase
                    end
                end
            end
        end
    end
endmodule

// File: verif/exc_vec_sva.sv
// checker: port relations of the exception unit, bound to its top module.
// assumes a single clock domain.
`timescale 1ns/1ps
module exc_vec_sva (
    input wire logic              i_clock,
    input wire logic              i_rst,
    input wire logic              i_ctl_write,
    input wire logic [15:0]       i_ctl_wdata,
    input wire logic [15:0]       o_ctl_rdata,
    input wire exc_pkg::status_t  o_status,
    input wire logic              o_system_mode,
    input wire logic              o_ack_req,
    input wire logic              i_ack_done,
    input wire exc_pkg::mem_req_t o_mem,
    input wire logic              i_mem_ready,
    input wire logic [15:0]       i_mem_rdata
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    sequence s_area_done;
        o_mem.req && o_mem.op == exc_pkg::M_AREA_READ && i_mem_ready;
    endsequence
    sequence s_pop_done;
        o_mem.req && o_mem.op == exc_pkg::M_POP && i_mem_ready;
    endsequence
    base_low_zero_a: assert property (o_ctl_rdata[7:0] == 8'h00)
        else $error("base pointer low byte not zero");
    base_write_a: assert property (
        i_ctl_write |=> o_ctl_rdata[15:8] == $past(i_ctl_wdata[15:8]))
        else $error("base pointer write lost");
    ack_mode_a: assert property (o_ack_req |-> o_system_mode)
        else $error("acknowledge outside system mode");
    ack_hold_a: assert property (o_ack_req && !i_ack_done |=> o_ack_req)
        else $error("acknowledge dropped early");
    mem_hold_a: assert property (o_mem.req && !i_mem_ready |=> $stable(o_mem))
        else $error("memory request changed before ready");
    area_range_a: assert property (
        o_mem.req && o_mem.op == exc_pkg::M_AREA_READ |->
        !o_mem.addr[0] && ((o_mem.addr - o_ctl_rdata) inside {[16'h0004:16'h021C]}))
        else $error("status area read outside area");
    entry_load_a: assert property (
        s_area_done ##1 !o_mem.req |=> o_status.load && o_status.pc == $past(i_mem_rdata, 2))
        else $error("loaded pc not taken up");
    return_load_a: assert property (
        s_pop_done ##1 !o_mem.req |-> ##[0:1] o_status.load)
        else $error("return did not load status");
endmodule

// File: verif/exception_vectoring_priority_test.sv
// testbench: exception unit with partner memory; traps, vectors, masks, priority, reset.
// assumes base high byte 07, so every control word loaded from the area keeps both enables set.
`timescale 1ns/1ps
module exception_vectoring_priority_test;
    localparam logic [15:0] BASE = 16'h0700;
    logic clk = 1'b0, rst = 1'b1, bnd = 1'b0, inc = 1'b0, trap = 1'b0, ret = 1'b0, wr = 1'b0;
    logic slow = 1'b0, vec_n = 1'b1, nvec_n = 1'b1, nmi_n = 1'b1, seg_n = 1'b1;
    logic ack_req, ack_done, rdy, busy;
    logic [15:0] nxt = 16'h2468, cur = 16'h0BAD, flag_control_word = 16'h0000, id_val = 16'h0000;
    logic [15:0] rd, ack_id, mrd;
    exc_pkg::kind_t    tkind = exc_pkg::K_EXT, akind;
    exc_pkg::kind_t    acks [$];
    exc_pkg::status_t  st;
    exc_pkg::mem_req_t mem;
    int err_count = 0, n_compared = 0, loads = 0;
    always #2.5 clk = ~clk;
    exception_vectoring_priority dut_u (
        .i_clock(clk), .i_rst(rst), .i_boundary(bnd), .i_next_pc(nxt), .i_cur_pc(cur),
        .i_block_incomplete(inc), .i_fcw(flag_control_word), .i_trap_req(trap), .i_trap_kind(tkind),
        .i_trap_pc(16'h1357), .i_trap_word(16'hC0DE), .i_return_req(ret),
        .i_ctl_write(wr), .i_ctl_wdata(16'h07A5), .o_ctl_rdata(rd), .o_status(st),
        .o_busy(busy), .o_system_mode(), .i_vectored_request_n(vec_n),
        .i_nonvectored_request_n(nvec_n), .i_nmi_n(nmi_n), .i_segment_fault_input_n(seg_n),
        .o_ack_req(ack_req), .o_ack_kind(akind), .i_ack_done(ack_done), .i_ack_id(ack_id),
        .o_mem(mem), .i_mem_ready(rdy), .i_mem_rdata(mrd));
    exc_peer peer_u (
        .i_clock(clk), .i_rst(rst), .i_mem(mem), .i_slow(slow), .i_ack_req(ack_req),
        .i_id(id_val), .o_mem_ready(rdy), .o_mem_rdata(mrd), .o_ack_done(ack_done),
        .o_ack_id(ack_id));
    always @(posedge clk) begin
        if (st.load === 1'b1) loads <= loads + 1;
        if (ack_req === 1'b1 && ack_done === 1'b1) begin
            acks.push_back(akind);
            // requester holds its level until acknowledged
            if (akind == exc_pkg::K_VEC) vec_n <= 1'b1;
            if (akind == exc_pkg::K_NVEC) nvec_n <= 1'b1;
            if (akind == exc_pkg::K_SEG) seg_n <= 1'b1;
            if (akind == exc_pkg::K_NMI) nmi_n <= 1'b1;
        end
    end
    task automatic finish_test();
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [15:0] stk(input logic [3:0] d);
        return peer_u.stack_q[peer_u.sp_q - d];
    endfunction
    task automatic pulse_bnd();
        bnd = 1'b1;
        step(1);
        bnd = 1'b0;
    endtask
    // bounded waits: a hang shows as a failed compare, not a stall
    task automatic wait_idle();
        for (int n = 0; n < 400 && busy !== 1'b0; n++) step(1);
        chk({15'h0, busy}, 16'h0000);
    endtask
    task automatic wait_load();
        for (int n = 0; n < 400 && st.load !== 1'b1; n++) step(1);
        chk({15'h0, st.load}, 16'h0001);
    endtask
    task automatic t_trap(input exc_pkg::kind_t k, input logic [15:0] ofs, rpc);
        trap = 1'b1;
        tkind = k;
        step(1);
        trap = 1'b0;
        flag_control_word = 16'h4000;
        pulse_bnd();
        wait_load();
        chk(st.pc, ~(BASE + ofs + 16'h0002));
        chk(st.flag_control_word, ~(BASE + ofs));
        wait_idle();
        chk(stk(4'h3), rpc);
        chk(stk(4'h2), 16'h4000);
        chk(stk(4'h1), 16'hC0DE);
        ret = 1'b1;
        step(1);
        ret = 1'b0;
        wait_load();
        chk(st.pc, rpc);
        chk(st.flag_control_word, 16'h4000);
        wait_idle();
    endtask
    task automatic t_vec();
        slow = 1'b1;
        inc = 1'b1;
        id_val = 16'hAB07;
        vec_n = 1'b0;
        flag_control_word = 16'h1000;
        step(3);
        pulse_bnd();
        wait_load();
        chk(st.pc, ~(BASE + 16'h001E + 16'h000E));
        chk(st.flag_control_word, ~(BASE + 16'h001C));
        wait_idle();
        chk(stk(4'h3), 16'h0BAD);
        chk(stk(4'h1), 16'hAB07);
        slow = 1'b0;
        inc = 1'b0;
    endtask
    task automatic t_mask();
        loads = 0;
        vec_n = 1'b0;
        nvec_n = 1'b0;
        flag_control_word = 16'h0000;
        step(3);
        pulse_bnd();
        wait_idle();
        vec_n = 1'b1;
        nvec_n = 1'b1;
        flag_control_word = 16'h1800;
        step(3);
        pulse_bnd();
        wait_idle();
        chk(16'(loads), 16'h0000);
    endtask
    task automatic t_prio();
        exc_pkg::kind_t ord [4] = '{exc_pkg::K_NMI, exc_pkg::K_SEG, exc_pkg::K_VEC,
                                    exc_pkg::K_NVEC};
        acks.delete();
        loads = 0;
        id_val = 16'h0004; // even identifier, as segmented requesters must give
        {nmi_n, seg_n, vec_n, nvec_n} = 4'h0;
        trap = 1'b1;
        tkind = exc_pkg::K_PRIV;
        step(1);
        trap = 1'b0;
        step(2);
        pulse_bnd();
        wait_idle();
        chk(16'(loads), 16'h0005);
        chk(16'(acks.size()), 16'h0004);
        foreach (ord[i]) chk({13'h0, acks[i]}, {13'h0, ord[i]});
        chk(st.pc, ~(BASE + 16'h001A));
    endtask
    task automatic t_reset();
        trap = 1'b1;
        step(1);
        trap = 1'b0;
        pulse_bnd();
        step(2);
        rst = 1'b1;
        step(1);
        chk({15'h0, busy}, 16'h0000);
        chk(rd, 16'h0000);
        rst = 1'b0;
        step(1);
    endtask
    task automatic t_base();
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        step(1);
        chk(rd, BASE);
    endtask
    initial begin
        step(10);
        rst = 1'b0;
        step(1);
        t_base();
        t_trap(exc_pkg::K_EXT, 16'h0004, 16'h1357);
        t_trap(exc_pkg::K_PRIV, 16'h0008, 16'h1357);
        t_trap(exc_pkg::K_SYSCALL, 16'h000C, 16'h2468);
        t_vec();
        t_mask();
        t_prio();
        t_reset();
        t_base();
        finish_test();
    end
    initial begin
        #200000;
        err_count++;
        finish_test();
    end
endmodule
bind exception_vectoring_priority exc_vec_sva sva_u (
    .i_clock(i_clock), .i_rst(i_rst), .i_ctl_write(i_ctl_write), .i_ctl_wdata(i_ctl_wdata),
    .o_ctl_rdata(o_ctl_rdata), .o_status(o_status), .o_system_mode(o_system_mode),
    .o_ack_req(o_ack_req), .i_ack_done(i_ack_done), .o_mem(o_mem),
    .i_mem_ready(i_mem_ready), .i_mem_rdata(i_mem_rdata));
